/* File: common/vrc_pkg.sv */
package vrc_pkg;
  // Register word offsets (byte addresses, one aligned word each)
  localparam logic [3:0] TRIM_OFFSET = 4'h0;
  localparam logic [3:0] CTRL_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h8;
  localparam logic [3:0] IRQ_CLEAR_OFFSET = 4'hC;
  localparam logic [4:0] IRQ_ENABLE_OFFSET = 5'h10;
  // Control and status field positions
  localparam int ENABLE_BIT = 7;
  localparam int STABLE_BIT = 2;
  localparam int MODE_LSB = 0;
  // Mode encodings
  typedef enum logic [1:0] {
    VRC_MODE_BANDGAP = 2'b00,
    VRC_MODE_LOWPWR = 2'b01,
    VRC_MODE_TIGHT = 2'b10,
    VRC_MODE_RSVD = 2'b11
  } vrc_mode_t;
  // Reset values
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // Stabilization time and its cycle count at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int STAB_TIME_US = 20;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
  // Interrupt status bit positions
  localparam int IRQ_STABLE_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // Analog control bundle
  typedef struct packed {
    logic bandgapOn;
    logic lowPowerBufOn;
    logic tightBufOn;
    logic [7:0] trimValue;
  } vrc_analog_t;
endpackage

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb
  import vrc_pkg::*;
();
  localparam int STAB = 8;
  logic clk, rst, read, write, waitrequest, referenceOutputPinEn, irq;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rdData;
  logic [3:0] byteenable;
  logic [1:0] response, rdResp;
  vrc_analog_t analogCtrl;
  int errors = 0;
  int compares = 0;
  // Rows: control byte, then bandgap, low-power, tight expected
  logic [10:0] rows [8] = '{11'h000, 11'h008, 11'h010, 11'h018,
                            11'h404, 11'h40E, 11'h415, 11'h418};

  vrc_top #(.STAB_COUNT(STAB)) uut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .analogCtrl(analogCtrl),
    .referenceOutputPinEn(referenceOutputPinEn), .irq(irq));

  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  // One Avalon transfer: raised after an edge, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check("waitrequest", 32'h0, {31'h0, waitrequest});
    rdData = readdata;
    rdResp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Read a register and compare its low byte
  task automatic rdChk(input string what, input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, {24'h0, exp}, {24'h0, rdData[7:0]});
  endtask

  // Settle outputs after a write
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask

  task automatic doReset;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (4000) @(posedge clk);
    errors++;
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdChk("trimReset", {1'b0, TRIM_OFFSET}, TRIM_RESET);
    check("offReset", 32'h0, {29'h0, analogCtrl[10:8]});
    $display("test reset done");
    // Enable and mode decode table
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, {1'b0, CTRL_OFFSET}, {24'h0, rows[i][10:3]});
      settle();
      check("analog", {29'h0, rows[i][2:0]}, {29'h0, analogCtrl[10:8]});
      check("pinEn", {31'h0, rows[i][0]}, {31'h0, referenceOutputPinEn});
      check("trimOut", {24'h0, TRIM_RESET}, {24'h0, analogCtrl.trimValue});
    end
    $display("test decode done");
    bus(1'b1, {1'b0, CTRL_OFFSET}, 32'h0);
    bus(1'b1, {1'b0, IRQ_CLEAR_OFFSET}, 32'h3);
    bus(1'b1, IRQ_ENABLE_OFFSET, 32'h1);
    // Startup, stable flag and interrupts
    bus(1'b1, {1'b0, CTRL_OFFSET}, 32'h80);
    rdChk("notStable", {1'b0, CTRL_OFFSET}, 8'h80);
    repeat (STAB + 6) @(posedge clk);
    rdChk("stable", {1'b0, CTRL_OFFSET}, 8'h84);
    check("irqStable", 32'h1, {31'h0, irq});
    rdChk("status", {1'b0, IRQ_STATUS_OFFSET}, 8'h01);
    bus(1'b1, {1'b0, IRQ_CLEAR_OFFSET}, 32'h1);
    settle();
    check("irqCleared", 32'h0, {31'h0, irq});
    bus(1'b1, {1'b0, CTRL_OFFSET}, 32'h82);
    rdChk("modeKeep", {1'b0, CTRL_OFFSET}, 8'h86);
    check("pinOn", 32'h1, {31'h0, referenceOutputPinEn});
    bus(1'b1, {1'b0, CTRL_OFFSET}, 32'h83);
    settle();
    rdChk("reserved", {1'b0, CTRL_OFFSET}, 8'h83);
    check("rsvdOff", 32'h0, {29'h0, analogCtrl[10:8]});
    rdChk("lostStatus", {1'b0, IRQ_STATUS_OFFSET}, 8'h02);
    check("irqMasked", 32'h0, {31'h0, irq});
    bus(1'b1, IRQ_ENABLE_OFFSET, 32'h3);
    settle();
    check("irqUnmasked", 32'h1, {31'h0, irq});
    bus(1'b1, {1'b0, IRQ_CLEAR_OFFSET}, 32'h2);
    settle();
    check("irqLostClr", 32'h0, {31'h0, irq});
    $display("test stable done");
    // Leaving reserved mode restarts the count
    bus(1'b1, {1'b0, CTRL_OFFSET}, 32'h81);
    rdChk("restart", {1'b0, CTRL_OFFSET}, 8'h81);
    repeat (STAB + 6) @(posedge clk);
    rdChk("restable", {1'b0, CTRL_OFFSET}, 8'h85);
    bus(1'b1, {1'b0, CTRL_OFFSET}, 32'h01);
    rdChk("disabled", {1'b0, CTRL_OFFSET}, 8'h01);
    $display("test restart done");
    // Trim write, byte enable refusal, unmapped access
    bus(1'b1, {1'b0, TRIM_OFFSET}, 32'h3C);
    settle();
    check("trimApplied", 32'h3C, {24'h0, analogCtrl.trimValue});
    byteenable <= 4'h0;
    bus(1'b1, {1'b0, TRIM_OFFSET}, 32'h55);
    byteenable <= 4'hF;
    rdChk("trimKept", {1'b0, TRIM_OFFSET}, 8'h3C);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapResp", 32'h2, {30'h0, rdResp});
    check("unmapData", 32'h0, rdData);
    $display("test access done");
    // Second reset reloads nominal trim
    doReset();
    rdChk("trimReload", {1'b0, TRIM_OFFSET}, TRIM_RESET);
    rdChk("ctrlReload", {1'b0, CTRL_OFFSET}, 8'h00);
    $display("test rereset done");
    conclude();
  end
endmodule

/* File: src/vrc_stab_counter.sv */
`timescale 1ns/1ps
// Counts stabilization time while run is high; restarts on restart pulse
module vrc_stab_counter
  import vrc_pkg::*;
#(
  parameter int CYCLES = STAB_CYCLES
)
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Async reset
  input wire logic run, // Count enable level
  input wire logic restart, // Restart pulse
  output logic done // Count reached
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count_r;
  logic done_r;
  wire atEnd = (count_r == LAST);

  // Counter and done flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= '0;
      done_r <= 1'b0;
    end
    else if (restart || !run)
    begin
      count_r <= '0;
      done_r <= 1'b0;
    end
    else if (!done_r)
    begin
      count_r <= atEnd ? count_r : count_r + CW'(1);
      done_r <= atEnd;
    end
  end
  assign done = done_r;
endmodule

/* File: src/vrc_top.sv */
`timescale 1ns/1ps
// Function
// [R1] Enable low turns everything off
// [R2] Mode 00: bandgap only, buffers off
// [R3] Mode 01: bandgap plus low-power buffer
// [R4] Mode 10: bandgap plus tight buffer, pin
// [R5] Trim applied in every enabled mode
// [R6] Stable flag low until startup done
// [R7] Mode change keeps stable flag set
// [R8] Mode 11 acts as disabled
// [R9] Counter restarts on enable rise
// [R10] Reset loads nominal trim value
// [R11] Enable at control bit 7
// [R12] Stable flag at control bit 2
// [R13] Mode field at control bits 1:0
module vrc_top
  import vrc_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
)
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Async reset, active high
  input wire logic [4:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  output logic [1:0] response, // Avalon response
  output vrc_analog_t analogCtrl, // Bandgap and buffer controls
  output logic referenceOutputPinEn, // Tight buffer drives pin
  output logic irq // Level interrupt
);
  logic [7:0] trimValue_r;
  logic referenceEnable_r;
  logic [1:0] mode_r;
  logic stableFlag_r;
  logic [IRQ_WIDTH-1:0] irqStatus_r;
  logic [IRQ_WIDTH-1:0] irqEnable_r;
  logic enablePrev_r;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [1:0] response_r;
  vrc_analog_t analog_r;
  logic counterDone;

  // Bus access decode; one wait cycle then ack
  wire access = (read || write) && !ack_r;
  wire wrStrobe = write && ack_r;
  wire lane0 = byteenable[0];
  wire hitTrim = (address == {1'b0, TRIM_OFFSET});
  wire hitCtrl = (address == {1'b0, CTRL_OFFSET});
  wire hitStat = (address == {1'b0, IRQ_STATUS_OFFSET});
  wire hitClr = (address == {1'b0, IRQ_CLEAR_OFFSET});
  wire hitIen = (address == IRQ_ENABLE_OFFSET);
  wire hitAny = hitTrim || hitCtrl || hitStat || hitClr || hitIen;

  // Mode decode
  wire modeActive = referenceEnable_r && (mode_r != VRC_MODE_RSVD);
  wire enableRise = modeActive && !enablePrev_r;
  wire stableRise = counterDone && !stableFlag_r && modeActive;
  wire stableLost = stableFlag_r && !modeActive;
  wire [IRQ_WIDTH-1:0] irqEvents = {stableLost, stableRise};
  wire [IRQ_WIDTH-1:0] irqClear =
    (wrStrobe && hitClr && lane0) ? writedata[IRQ_WIDTH-1:0] : '0;

  // Read mux
  wire [7:0] ctrlRead = {referenceEnable_r, 4'h0, stableFlag_r, mode_r};
  wire [31:0] rdMux =
    hitTrim ? {24'h0, trimValue_r} :
    hitCtrl ? {24'h0, ctrlRead} :
    hitStat ? {30'h0, irqStatus_r} :
    hitIen ? {30'h0, irqEnable_r} : 32'h0;

  // Stabilization counter runs while active
  vrc_stab_counter #(
    .CYCLES(STAB_COUNT)
  ) u_stab (
    .clk(clk),
    .rst(rst),
    .run(modeActive),
    .restart(enableRise),
    .done(counterDone)
  );

  // Bus handshake
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0;
      response_r <= 2'h0;
    end
    else
    begin
      ack_r <= access;
      readdata_r <= rdMux;
      response_r <= hitAny ? 2'h0 : 2'h2;
    end
  end

  // Trim register, nominal on reset
  // [R10] nominal trim load
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      trimValue_r <= TRIM_RESET;
    else if (wrStrobe && hitTrim && lane0)
      trimValue_r <= writedata[7:0];
  end

  // Control register fields
  // [R11] enable bit 7
  // [R13] mode bits 1:0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      referenceEnable_r <= 1'b0;
      mode_r <= MODE_RESET;
    end
    else if (wrStrobe && hitCtrl && lane0)
    begin
      referenceEnable_r <= writedata[ENABLE_BIT];
      mode_r <= writedata[MODE_LSB +: 2];
    end
  end

  // Stable flag from counter; a change among modes 00, 01 and 10 does not clear it
  // [R6] stable after startup
  // [R7] mode change keeps flag
  // [R9] restart on enable rise
  // [R12] stable bit 2
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stableFlag_r <= 1'b0;
      enablePrev_r <= 1'b0;
    end
    else
    begin
      enablePrev_r <= modeActive;
      stableFlag_r <= modeActive && (counterDone || stableFlag_r);
    end
  end

  // Analog controls
  // [R1] disabled all off
  // [R8] reserved mode off
  // [R2] bandgap only
  // [R3] low-power buffer
  // [R4] tight buffer to pin
  // [R5] trim applied
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      analog_r <= '{bandgapOn: 1'b0, lowPowerBufOn: 1'b0, tightBufOn: 1'b0,
                    trimValue: TRIM_RESET};
    else
    begin
      analog_r.bandgapOn <= modeActive;
      analog_r.lowPowerBufOn <= modeActive && (mode_r == VRC_MODE_LOWPWR);
      analog_r.tightBufOn <= modeActive && (mode_r == VRC_MODE_TIGHT);
      analog_r.trimValue <= trimValue_r;
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqStatus_r <= '0;
      irqEnable_r <= '0;
    end
    else
    begin
      irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
      if (wrStrobe && hitIen && lane0)
        irqEnable_r <= writedata[IRQ_WIDTH-1:0];
    end
  end

  assign waitrequest = !ack_r;
  assign readdata = readdata_r;
  assign response = response_r;
  assign analogCtrl = analog_r;
  assign referenceOutputPinEn = analog_r.tightBufOn;
  assign irq = |(irqStatus_r & irqEnable_r);

  // Cycles since the last enable rise, for the startup time check
  logic [31:0] sinceEnable_r;
  localparam logic [31:0] STAB_MIN = 32'(STAB_COUNT);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sinceEnable_r <= 32'h0;
    else if (!modeActive || enableRise)
      sinceEnable_r <= 32'h0;
    else if (sinceEnable_r != 32'hFFFFFFFF)
      sinceEnable_r <= sinceEnable_r + 32'h1;
  end

  // Assertions
  property p_off_when_disabled; // [R1]
    @(posedge clk) disable iff (rst)
    !referenceEnable_r |=> !analogCtrl.bandgapOn && !analogCtrl.lowPowerBufOn
      && !analogCtrl.tightBufOn;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) // [R1]
    else $error("outputs on while disabled");

  property p_bandgap_only; // [R2]
    @(posedge clk) disable iff (rst)
    referenceEnable_r && mode_r == VRC_MODE_BANDGAP |=>
      analogCtrl.bandgapOn && !analogCtrl.lowPowerBufOn && !analogCtrl.tightBufOn;
  endproperty
  a_bandgap_only: assert property (p_bandgap_only) // [R2]
    else $error("mode 00 wrong");

  property p_lowpwr; // [R3]
    @(posedge clk) disable iff (rst)
    referenceEnable_r && mode_r == VRC_MODE_LOWPWR |=>
      analogCtrl.lowPowerBufOn && !analogCtrl.tightBufOn && !referenceOutputPinEn;
  endproperty
  a_lowpwr: assert property (p_lowpwr) // [R3]
    else $error("mode 01 wrong");

  property p_tight; // [R4]
    @(posedge clk) disable iff (rst)
    referenceEnable_r && mode_r == VRC_MODE_TIGHT |=>
      analogCtrl.tightBufOn && referenceOutputPinEn && !analogCtrl.lowPowerBufOn;
  endproperty
  a_tight: assert property (p_tight) // [R4]
    else $error("mode 10 wrong");

  property p_trim; // [R5]
    @(posedge clk) disable iff (rst)
    ##1 analogCtrl.trimValue == $past(trimValue_r);
  endproperty
  a_trim: assert property (p_trim) // [R5]
    else $error("trim not applied");

  property p_stable_wait; // [R6]
    @(posedge clk) disable iff (rst)
    enableRise |=> !stableFlag_r [*2];
  endproperty
  a_stable_wait: assert property (p_stable_wait) // [R6]
    else $error("stable too early");

  property p_mode_keeps; // [R7]
    @(posedge clk) disable iff (rst)
    stableFlag_r && modeActive && $changed(mode_r)
      |=> stableFlag_r;
  endproperty
  a_mode_keeps: assert property (p_mode_keeps) // [R7]
    else $error("mode change cleared stable");

  property p_reserved; // [R8]
    @(posedge clk) disable iff (rst)
    mode_r == VRC_MODE_RSVD |=> !analogCtrl.bandgapOn && !stableFlag_r;
  endproperty
  a_reserved: assert property (p_reserved) // [R8]
    else $error("reserved mode not off");

  property p_clear_on_disable; // [R9]
    @(posedge clk) disable iff (rst)
    $fell(referenceEnable_r) |=> !stableFlag_r [*2];
  endproperty
  a_clear_on_disable: assert property (p_clear_on_disable) // [R9]
    else $error("stable not cleared");

  property p_ctrl_read; // [R12]
    @(posedge clk) disable iff (rst)
    !waitrequest && read && hitCtrl |->
      readdata[STABLE_BIT] == $past(stableFlag_r) && readdata[6:3] == 4'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // [R12]
    else $error("control read wrong");

  property p_stable_time; // [R6]
    @(posedge clk) disable iff (rst)
    $rose(stableFlag_r) |-> sinceEnable_r >= STAB_MIN;
  endproperty
  a_stable_time: assert property (p_stable_time) // [R6]
    else $error("stable before startup time");

  property p_restart; // [R9]
    @(posedge clk) disable iff (rst)
    enableRise |=> !counterDone && !stableFlag_r;
  endproperty
  a_restart: assert property (p_restart) // [R9]
    else $error("counter not restarted");

  property p_stable_irq; // [R6]
    @(posedge clk) disable iff (rst)
    stableRise |=> irqStatus_r[IRQ_STABLE_BIT];
  endproperty
  a_stable_irq: assert property (p_stable_irq) // [R6]
    else $error("stable event not recorded");

  property p_lost_irq; // [R8]
    @(posedge clk) disable iff (rst)
    stableLost |=> irqStatus_r[IRQ_LOST_BIT];
  endproperty
  a_lost_irq: assert property (p_lost_irq) // [R8]
    else $error("lost event not recorded");

  property p_one_buffer; // [R3]
    @(posedge clk) disable iff (rst)
    analogCtrl.lowPowerBufOn || analogCtrl.tightBufOn |->
      analogCtrl.bandgapOn && !(analogCtrl.lowPowerBufOn && analogCtrl.tightBufOn);
  endproperty
  a_one_buffer: assert property (p_one_buffer) // [R3]
    else $error("buffer state wrong");

  property p_wait_released;
    @(posedge clk) disable iff (rst)
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_released: assert property (p_wait_released)
    else $error("waitrequest low too long");

  property p_ack_needs_req;
    @(posedge clk) disable iff (rst)
    !waitrequest |-> $past(read || write);
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req)
    else $error("answer without request");

  property p_unmapped;
    @(posedge clk) disable iff (rst)
    !waitrequest && !hitAny |-> response == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  c_stable: cover property (@(posedge clk) disable iff (rst) $rose(stableFlag_r));
  c_tight: cover property (@(posedge clk) disable iff (rst) $rose(referenceOutputPinEn));
  c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_lost: cover property (@(posedge clk) disable iff (rst) $rose(irqStatus_r[IRQ_LOST_BIT]));
  c_restart: cover property (@(posedge clk) disable iff (rst) enableRise);
endmodule
